//--- rtl/cps_pkg.sv
/*
 * Constants for the current profile setup register bank: frame layout,
 * message selectors, field positions, reset values and timer sizes.
 * Assumes a 32-bit frame, most significant bit first.
 */
package cps_pkg;
  // ==========================================================================
  // Frame layout
  localparam int CPS_FRAME_BITS = 32;
  localparam int CPS_RW_BIT = 31;
  localparam int CPS_SEL_HI = 30;
  localparam int CPS_SEL_LO = 27;
  localparam int CPS_CH_HI = 26;
  localparam int CPS_CH_LO = 24;
  localparam logic [3:0] CPS_SEL_SETUP1 = 4'h9;
  localparam logic [3:0] CPS_SEL_SETUP2 = 4'ha;
  localparam logic [5:0] CPS_BIT_LAST = 6'h1f;
  localparam logic [5:0] CPS_BIT_FULL = 6'h20;

  // ==========================================================================
  // First setup register: thresholds 3..1 and counts 3..1
  localparam int CPS_S1_HI = 23;
  localparam int CPS_S1_LO = 0;
  localparam int CPS_S1_W = 24;
  localparam logic [23:0] CPS_S1_RESET = 24'h000000;

  // ==========================================================================
  // Second setup register: time-out and zone-3 selector
  localparam int CPS_TO_HI = 9;
  localparam int CPS_TO_LO = 4;
  localparam int CPS_TO_W = 6;
  localparam int CPS_Z3_HI = 1;
  localparam int CPS_Z3_LO = 0;
  localparam logic [5:0] CPS_TO_RESET = 6'h00;
  localparam logic [1:0] CPS_Z3_RESET = 2'h0;

  // ==========================================================================
  // Time-out timer: one unit is this many ADC sample periods plus one
  localparam logic [3:0] CPS_SAMPLES_PER_UNIT_M1 = 4'hf;

  typedef enum logic [0:0] {
    CPS_IDLE = 1'b0,
    CPS_SHIFT = 1'b1
  } cps_spi_e;
endpackage : cps_pkg

//--- rtl/cps_setup_regs.sv
/*
 * Current profile setup register bank with its SPI slave and the
 * per-channel detection time-out supervision.
 * Assumes SPI mode 0 from a host master, sclk slow against clk_sys; the
 * answer to a frame is shifted out during the following frame.
 */
`timescale 1ns/1ps
// Function
// R01: Selector 1001 in bits 30:27 addresses setup register 1 of the channel in bits 26:24.
// R02: Selector 1010 addresses setup register 2 (time-out, zone-3 select) of that channel.
// R03: Setup 1 holds thresholds 3,2,1 at 23:20,19:16,15:12 and counts 3,2,1 at 11:8,7:4,3:0.
// R04: All threshold and count fields reset to zero on every channel.
// R05: Time-out sits at 9:4, one unit is 16 ADC sample periods, and resets to zero.
// R06: Zone-3 selector 00..11 picks the sample one to four back for the difference.
// R07: The setup 2 answer echoes selector and channel, carries time-out at 9:4 and zone-3 selector at 1:0, all else zero.
// R08: The setup 1 answer echoes selector, channel and all six stored fields in place.
// R09: Bit 31 set writes, clear reads without change; bit 31 of every answer is zero.
// R10: Each of the eight channels keeps its own copy of both setup registers.
// R11: A channel's time-out flag rises when its time-out expires before detection ends.
// R12: A channel's interrupted flag rises when the gate goes off before detection ends.
module cps_setup_regs
  import cps_pkg::*;
#(
  parameter int NCH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // SPI pins
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  // Detection sequencer side
  input wire logic adc_sample_tick,
  input wire logic [NCH-1:0] detect_start,
  input wire logic [NCH-1:0] detect_done,
  input wire logic [NCH-1:0] gate_off,
  input wire logic [NCH-1:0] flag_clear,
  // Configuration and flags
  output logic [NCH*CPS_S1_W-1:0] threshold_count_cfg,
  output logic [NCH*CPS_TO_W-1:0] timeout_cfg,
  output logic [NCH*3-1:0] sample_difference_distance,
  output logic [NCH-1:0] timeout_flag,
  output logic [NCH-1:0] detect_intr_flag
);

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] sclk_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] mosi_sync_reg;
  logic sclk_prev_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclk_sync_reg <= 2'h0;
      cs_sync_reg <= 2'h3;
      mosi_sync_reg <= 2'h0;
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], spi_sclk};
      cs_sync_reg <= {cs_sync_reg[0], spi_cs_n};
      mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi};
      sclk_prev_reg <= sclk_sync_reg[1];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_prev_reg;
  assign cs_active = ~cs_sync_reg[1];

  // ==========================================================================
  // Frame shifter and register file
  cps_spi_e state_reg, state_next;
  logic [31:0] rx_reg, rx_next;
  logic [31:0] tx_reg, tx_next;
  logic [31:0] resp_reg, resp_next;
  logic [5:0] cnt_reg, cnt_next;
  logic miso_reg, miso_next;
  logic [CPS_S1_W-1:0] s1_reg [NCH];
  logic [CPS_S1_W-1:0] s1_next [NCH];
  logic [CPS_TO_W-1:0] to_reg [NCH];
  logic [CPS_TO_W-1:0] to_next [NCH];
  logic [1:0] z3_reg [NCH];
  logic [1:0] z3_next [NCH];

  logic [3:0] f_sel;
  logic [2:0] f_ch;
  logic f_wr;
  assign f_sel = rx_reg[CPS_SEL_HI:CPS_SEL_LO];
  assign f_ch = rx_reg[CPS_CH_HI:CPS_CH_LO];
  assign f_wr = rx_reg[CPS_RW_BIT];

  always_comb begin
    state_next = state_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    resp_next = resp_reg;
    cnt_next = cnt_reg;
    miso_next = miso_reg;
    s1_next = s1_reg;
    to_next = to_reg;
    z3_next = z3_reg;
    case (state_reg)
      CPS_IDLE: begin
        if (cs_active) begin
          state_next = CPS_SHIFT;
          cnt_next = 6'h00;
          tx_next = resp_reg;
          miso_next = resp_reg[CPS_FRAME_BITS-1];
        end
      end
      CPS_SHIFT: begin
        if (!cs_active) begin
          state_next = CPS_IDLE;
          if (cnt_reg == CPS_BIT_FULL) begin
            resp_next = 32'h00000000; // [R09]
            if (f_sel == CPS_SEL_SETUP1) begin // [R01]
              if (f_wr) begin
                s1_next[f_ch] = rx_reg[CPS_S1_HI:CPS_S1_LO]; // [R03] [R09] [R10]
              end
              resp_next[CPS_SEL_HI:CPS_SEL_LO] = f_sel; // [R08]
              resp_next[CPS_CH_HI:CPS_CH_LO] = f_ch;
              resp_next[CPS_S1_HI:CPS_S1_LO] = f_wr ? rx_reg[CPS_S1_HI:CPS_S1_LO]
                                                    : s1_reg[f_ch];
            end else if (f_sel == CPS_SEL_SETUP2) begin // [R02]
              if (f_wr) begin
                to_next[f_ch] = rx_reg[CPS_TO_HI:CPS_TO_LO]; // [R05] [R10]
                z3_next[f_ch] = rx_reg[CPS_Z3_HI:CPS_Z3_LO];
              end
              resp_next[CPS_SEL_HI:CPS_SEL_LO] = f_sel; // [R07]
              resp_next[CPS_CH_HI:CPS_CH_LO] = f_ch;
              resp_next[CPS_TO_HI:CPS_TO_LO] = f_wr ? rx_reg[CPS_TO_HI:CPS_TO_LO]
                                                    : to_reg[f_ch];
              resp_next[CPS_Z3_HI:CPS_Z3_LO] = f_wr ? rx_reg[CPS_Z3_HI:CPS_Z3_LO]
                                                    : z3_reg[f_ch];
            end
          end
        end else begin
          if (sclk_rise && cnt_reg != CPS_BIT_FULL) begin
            rx_next = {rx_reg[CPS_FRAME_BITS-2:0], mosi_sync_reg[1]};
            cnt_next = cnt_reg + 6'h01;
          end
          if (sclk_fall && cnt_reg != CPS_BIT_FULL && cnt_reg != 6'h00) begin
            tx_next = {tx_reg[CPS_FRAME_BITS-2:0], 1'b0};
            miso_next = tx_reg[CPS_FRAME_BITS-2];
          end
        end
      end
      default: begin
        state_next = CPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= CPS_IDLE;
      rx_reg <= 32'h00000000;
      tx_reg <= 32'h00000000;
      resp_reg <= 32'h00000000;
      cnt_reg <= 6'h00;
      miso_reg <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        s1_reg[i] <= CPS_S1_RESET; // [R04]
        to_reg[i] <= CPS_TO_RESET; // [R05]
        z3_reg[i] <= CPS_Z3_RESET;
      end
    end else begin
      state_reg <= state_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      resp_reg <= resp_next;
      cnt_reg <= cnt_next;
      miso_reg <= miso_next;
      s1_reg <= s1_next;
      to_reg <= to_next;
      z3_reg <= z3_next;
    end
  end

  assign spi_miso = miso_reg;
  assign spi_miso_oe_n = ~(state_reg == CPS_SHIFT);

  // ==========================================================================
  // Per-channel outputs and detection time-out supervision
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic active_reg, active_next;
      logic [3:0] smp_reg, smp_next;
      logic [CPS_TO_W-1:0] unit_reg, unit_next;
      logic to_flag_reg, to_flag_next;
      logic int_flag_reg, int_flag_next;
      logic expire;

      assign threshold_count_cfg[g*CPS_S1_W +: CPS_S1_W] = s1_reg[g];
      assign timeout_cfg[g*CPS_TO_W +: CPS_TO_W] = to_reg[g];
      // Distance back to the subtracted sample
      assign sample_difference_distance[g*3 +: 3] = {1'b0, z3_reg[g]} + 3'h1; // [R06]

      // Zero time-out disables the timer
      assign expire = active_reg && adc_sample_tick && to_reg[g] != CPS_TO_RESET &&
                      smp_reg == CPS_SAMPLES_PER_UNIT_M1 &&
                      unit_reg == to_reg[g] - 6'h01; // [R05] [R11]

      always_comb begin
        active_next = active_reg;
        smp_next = smp_reg;
        unit_next = unit_reg;
        to_flag_next = to_flag_reg & ~flag_clear[g];
        int_flag_next = int_flag_reg & ~flag_clear[g];
        if (detect_start[g]) begin
          active_next = 1'b1;
          smp_next = 4'h0;
          unit_next = 6'h00;
        end else if (active_reg) begin
          if (detect_done[g]) begin
            active_next = 1'b0;
          end else if (gate_off[g]) begin
            active_next = 1'b0;
            int_flag_next = 1'b1; // [R12]
          end else if (expire) begin
            active_next = 1'b0;
            to_flag_next = 1'b1; // [R11]
          end else if (adc_sample_tick) begin
            smp_next = smp_reg + 4'h1;
            if (smp_reg == CPS_SAMPLES_PER_UNIT_M1) begin
              unit_next = unit_reg + 6'h01;
            end
          end
        end
      end

      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          active_reg <= 1'b0;
          smp_reg <= 4'h0;
          unit_reg <= 6'h00;
          to_flag_reg <= 1'b0;
          int_flag_reg <= 1'b0;
        end else begin
          active_reg <= active_next;
          smp_reg <= smp_next;
          unit_reg <= unit_next;
          to_flag_reg <= to_flag_next;
          int_flag_reg <= int_flag_next;
        end
      end

      assign timeout_flag[g] = to_flag_reg;
      assign detect_intr_flag[g] = int_flag_reg;
    end
  endgenerate

endmodule : cps_setup_regs

//--- testbench/cps_setup_regs_chk.sv
/* Port assertions for the setup register bank.
   Bound to cps_setup_regs from the bench top file. */
`timescale 1ns/1ps
module cps_setup_regs_chk
  import cps_pkg::*;
#(
  parameter int NCH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Watched ports
  input wire logic spi_cs_n,
  input wire logic spi_miso_oe_n,
  input wire logic adc_sample_tick,
  input wire logic [NCH-1:0] gate_off,
  input wire logic [NCH-1:0] flag_clear,
  input wire logic [NCH*CPS_S1_W-1:0] threshold_count_cfg,
  input wire logic [NCH*CPS_TO_W-1:0] timeout_cfg,
  input wire logic [NCH*3-1:0] sample_difference_distance,
  input wire logic [NCH-1:0] timeout_flag,
  input wire logic [NCH-1:0] detect_intr_flag
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_oe_idle: assert property (spi_cs_n && $past(spi_cs_n, 4) |-> spi_miso_oe_n)
    else $error("miso driven outside a frame");
  a_oe_start: assert property ($fell(spi_miso_oe_n) |-> !spi_cs_n && !$past(spi_cs_n, 2))
    else $error("miso enabled without select");
  a_s1_update: assert property ($changed(threshold_count_cfg) |-> spi_cs_n && $past(spi_cs_n, 2))
    else $error("setup 1 changed inside a frame");
  a_to_update: assert property ($changed(timeout_cfg) |-> spi_cs_n && $past(spi_cs_n, 2))
    else $error("setup 2 changed inside a frame");
  a_dist_range: assert property (sample_difference_distance[2:0] inside {3'h1, 3'h2, 3'h3, 3'h4})
    else $error("sample distance out of range");
  a_dist_update: assert property ($changed(sample_difference_distance) |->
    spi_cs_n && $past(spi_cs_n, 2))
    else $error("distance changed inside a frame");
  a_to_cause: assert property ($rose(timeout_flag[0]) |-> $past(adc_sample_tick) && timeout_cfg[5:0] != 6'h00)
    else $error("time-out flag without tick");
  a_to_sticky: assert property ($fell(timeout_flag[0]) |-> $past(flag_clear[0]))
    else $error("time-out flag dropped by itself");
  a_intr_cause: assert property ($rose(detect_intr_flag[1]) |-> $past(gate_off[1]))
    else $error("interrupted flag without gate off");
  a_intr_sticky: assert property ($fell(detect_intr_flag[1]) |-> $past(flag_clear[1]))
    else $error("interrupted flag dropped by itself");
endmodule : cps_setup_regs_chk

//--- testbench/cps_host.sv
/* Host SPI master model, mode 0, 160 ns bit clock, MSB first.
   The bench calls xfer or cut; sclk stands low outside frames. */
`timescale 1ns/1ps
module cps_host (
  // SPI pins
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    spi_cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      spi_mosi = tx[i];
      #80 spi_sclk = 1'b1;
      rx[i] = spi_miso;
      #80 spi_sclk = 1'b0;
    end
    #80 spi_cs_n = 1'b1;
    // Released data line shows the inverse level
    spi_mosi = ~spi_mosi;
    #160;
  endtask : xfer
  // Frame cut short after nbits clocks
  task automatic cut(input logic [31:0] tx, input int nbits);
    spi_cs_n = 1'b0;
    for (int i = 31; i > 31 - nbits; i--) begin
      spi_mosi = tx[i];
      #80 spi_sclk = 1'b1;
      #80 spi_sclk = 1'b0;
    end
    #80 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #160;
  endtask : cut
endmodule : cps_host

//--- testbench/cps_setup_regs_tb_top.sv
/* Self-checking bench for the setup register bank.
   Frames go through the host model; answers arrive one frame late. */
`timescale 1ns/1ps
`define CHK(a, b) \
  checked++; \
  if ((a) !== (b)) begin \
    fail_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
  end
module cps_setup_regs_tb_top
  import cps_pkg::*;
;
  // ==========================================================================
  // Signals
  logic clk_sys = 1'b0, rstn = 1'b0, adc_sample_tick = 1'b0;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
  wire spi_miso_w = spi_miso_oe_n ? 1'bz : spi_miso;
  logic [7:0] detect_start = '0, detect_done = '0, gate_off = '0, flag_clear = '0;
  logic [191:0] threshold_count_cfg;
  logic [47:0] timeout_cfg;
  logic [23:0] sample_difference_distance;
  logic [7:0] timeout_flag, detect_intr_flag;
  logic [31:0] prev_ans;
  logic have_prev = 1'b0;
  int fail_count = 0, checked = 0;
  localparam logic [23:0] D = 24'h5a3c96;
  always #5 clk_sys = ~clk_sys;
  cps_setup_regs u_cps_setup_regs (.clk_sys, .rstn, .spi_sclk, .spi_cs_n, .spi_mosi,
    .spi_miso, .spi_miso_oe_n, .adc_sample_tick, .detect_start, .detect_done, .gate_off,
    .flag_clear, .threshold_count_cfg, .timeout_cfg, .sample_difference_distance,
    .timeout_flag, .detect_intr_flag);
  cps_host u_cps_host (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso(spi_miso_w));
  // ==========================================================================
  // Tasks
  function automatic logic [31:0] s2a(logic [2:0] ch, logic [5:0] to, logic [1:0] z);
    return {1'b0, CPS_SEL_SETUP2, ch, 14'h0000, to, 2'h0, z};
  endfunction : s2a
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic frame(input logic [31:0] tx, input logic [31:0] ans);
    logic [31:0] rx;
    u_cps_host.xfer(tx, rx);
    if (have_prev) begin
      `CHK(rx, prev_ans)
    end
    prev_ans = ans;
    have_prev = 1'b1;
  endtask : frame
  task automatic tally_and_finish;
    if (fail_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // Sequence
  initial begin
    #200000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    step(12);
    rstn = 1'b1;
    step(4);
    `CHK(threshold_count_cfg, '0)
    `CHK(timeout_cfg, '0)
    frame({1'b0, CPS_SEL_SETUP1, 3'h3, 24'h0}, {1'b0, CPS_SEL_SETUP1, 3'h3, 24'h0});
    frame({1'b0, CPS_SEL_SETUP2, 3'h3, 24'h0}, s2a(3'h3, 6'h00, 2'h0));
    frame({1'b1, CPS_SEL_SETUP1, 3'h2, D}, {1'b0, CPS_SEL_SETUP1, 3'h2, D});
    frame({1'b0, CPS_SEL_SETUP1, 3'h2, 24'hffffff}, {1'b0, CPS_SEL_SETUP1, 3'h2, D});
    `CHK(threshold_count_cfg[48+:24], D)
    `CHK(threshold_count_cfg[120+:24], 24'h0)
    for (int v = 0; v < 4; v++) begin
      frame({1'b1, CPS_SEL_SETUP2, 3'h2, 14'h3fff, 6'h38 + 6'(v), 2'h3, 2'(v)},
        s2a(3'h2, 6'h38 + 6'(v), 2'(v)));
      `CHK(sample_difference_distance[6+:3], 3'(v + 1))
      `CHK(timeout_cfg[12+:6], 6'h38 + 6'(v))
    end
    frame({1'b1, 4'hc, 3'h2, 24'h0}, 32'h0);
    `CHK(threshold_count_cfg[48+:24], D)
    frame({1'b1, CPS_SEL_SETUP2, 3'h0, 14'h0, 6'h01, 4'h0}, s2a(3'h0, 6'h01, 2'h0));
    frame({1'b0, CPS_SEL_SETUP1, 3'h5, 24'h0}, {1'b0, CPS_SEL_SETUP1, 3'h5, 24'h0});
    // One time-out unit on channel 0
    detect_start[0] = 1'b1;
    step(1);
    detect_start[0] = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (i == 15) begin
        `CHK(timeout_flag[0], 1'b0)
      end
      adc_sample_tick = 1'b1;
      step(1);
      adc_sample_tick = 1'b0;
      step(1);
    end
    `CHK(timeout_flag[0], 1'b1)
    // Gate off during and after detection
    detect_start[2:1] = 2'h3;
    step(1);
    detect_start[2:1] = 2'h0;
    detect_done[2] = 1'b1;
    step(1);
    detect_done[2] = 1'b0;
    gate_off[2:1] = 2'h3;
    step(2);
    gate_off[2:1] = 2'h0;
    `CHK(detect_intr_flag[2:1], 2'h1)
    `CHK(timeout_flag[1], 1'b0)
    flag_clear = 8'hff;
    step(1);
    flag_clear = 8'h00;
    step(1);
    `CHK({timeout_flag, detect_intr_flag}, 16'h0000)
    // Cut write frame leaves register and answer alone
    u_cps_host.cut({1'b1, CPS_SEL_SETUP1, 3'h2, 24'h0}, 16);
    `CHK(threshold_count_cfg[48+:24], D)
    frame({1'b0, CPS_SEL_SETUP2, 3'h2, 24'h0}, s2a(3'h2, 6'h3b, 2'h3));
    frame({1'b0, CPS_SEL_SETUP1, 3'h2, 24'h0}, {1'b0, CPS_SEL_SETUP1, 3'h2, D});
    // Reset in mid-run clears every channel
    rstn = 1'b0;
    step(2);
    rstn = 1'b1;
    step(4);
    `CHK(threshold_count_cfg, '0)
    `CHK({timeout_cfg, sample_difference_distance}, {48'h0, {8{3'h1}}})
    have_prev = 1'b0;
    frame({1'b0, CPS_SEL_SETUP2, 3'h2, 24'h0}, s2a(3'h2, 6'h00, 2'h0));
    frame({1'b0, CPS_SEL_SETUP1, 3'h2, 24'h0}, {1'b0, CPS_SEL_SETUP1, 3'h2, 24'h0});
    tally_and_finish;
  end
endmodule : cps_setup_regs_tb_top
bind cps_setup_regs cps_setup_regs_chk #(.NCH(NCH)) u_cps_setup_regs_chk (.clk_sys, .rstn,
  .spi_cs_n, .spi_miso_oe_n, .adc_sample_tick, .gate_off, .flag_clear, .threshold_count_cfg,
  .timeout_cfg, .sample_difference_distance, .timeout_flag, .detect_intr_flag);
